// >>> src/lsr_pkg.sv
// register map, field positions and reset values of the led driver register bank
// shared by the register bank top and its test side; no logic here
package lsr_pkg;

    // byte offsets on the register port
    localparam logic [7:0] OFS_FAULT_STATUS  = 8'h02;
    localparam logic [7:0] OFS_IDENTITY      = 8'h03;
    localparam logic [7:0] OFS_DC_LEVEL      = 8'h07;
    localparam logic [7:0] OFS_CONFIG        = 8'h08;
    localparam logic [7:0] OFS_CHANNEL_MASK  = 8'h09;

    // fault and status bit positions
    localparam int STS_FAULT_BIT      = 0;
    localparam int STS_THERMAL_BIT    = 1;
    localparam int STS_OVERCURR_BIT   = 2;
    localparam int STS_BACKLIGHT_BIT  = 3;
    localparam int STS_ONE_SHUT_BIT   = 4;
    localparam int STS_TWO_SHUT_BIT   = 5;

    // identity fields
    localparam int ID_MARKER_BIT      = 7;
    localparam int ID_MAKER_LSB       = 3;
    localparam int ID_REV_LSB         = 0;
    localparam logic [3:0] MAKER_NOT_IMPLEMENTED = 4'hf;
    localparam logic [2:0] FIRST_REVISION        = 3'h0;

    // configuration fields
    localparam int CFG_SHORT_LSB      = 0;
    localparam int CFG_FREQ_BIT       = 2;

    // channel mask layout
    localparam int NUM_CHANNELS       = 6;

    // reset values
    localparam logic [7:0] RST_FAULT_STATUS = 8'h00;
    localparam logic [7:0] RST_DC_LEVEL     = 8'hff;
    localparam logic [7:0] RST_CONFIG       = 8'hff;
    localparam logic [7:0] RST_CHANNEL_MASK = 8'hff;
    localparam logic [7:0] RST_READ_DATA    = 8'h00;

endpackage

// >>> src/lsr_sync.sv
// two-stage synchroniser for a group of slow level signals
// assumes each bit is a level that stays for many clock cycles
`timescale 1ns/1ps
module lsr_sync #(
    parameter int WIDTH = 8
) (
    input  wire logic             sys_clk,
    input  wire logic             resetn,
    input  wire logic             clk_en,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta;

    // first stage feeds only the second stage
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            meta     <= '0;
            sync_out <= '0;
        end else if (clk_en) begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end

endmodule

// >>> src/lsr_regs.sv
// register bank of a six-channel led backlight driver: status, identity,
// dc level, boost/short configuration and channel mask with fault readback
// assumes a byte protocol engine outside gives one-cycle read and write
// strobes with an address; analog monitors drive the raw fault levels
//
// Behaviour
// [R1] identity bit 7 always reads one, marking a panel driver.
// [R2] identity bits 6..3 hold maker code, bits 2..0 silicon revision.
// [R3] identity register is read-only; writes change nothing.
// [R4] maker code 0-8 other vendors, 10-14 reserved, 15 not implemented.
// [R5] silicon revision starts at zero, one higher per released revision.
// [R6] status bit 5 two channels shut down, bit 4 one channel shut down.
// [R7] status bit 3 shows backlight lit (one) or off (zero).
// [R8] status bit 2 input overcurrent, bit 1 thermal shutdown, live.
// [R9] status bit 0 is the OR of the fault conditions.
// [R10] dc level is an 8-bit read/write register, changeable in operation.
// [R11] writing dc level changes only the dc setting, not pwm.
// [R12] reading dc level returns the level in force.
// [R13] dc level resets to all ones.
// [R14] configuration bits 1..0 select short threshold or disable it.
// [R15] configuration bit 2 selects 1200 kHz (one) or 600 kHz (zero).
// [R16] configuration resets to all ones.
// [R17] mask bit n drives channel n for n 0..5; bits 7,6 reserved.
// [R18] mask write enables channels written one, disables the rest.
// [R19] mask read gives zero for disabled or faulted channels.
// [R20] disabling then re-enabling a channel clears its fault and retries it.
// [R21] mask resets to all ones.
// [R22] summary fault is sticky until backlight command toggles or written low.
// [R23] one-channel flag at one or more faults, two-channel at two or more.
// [R24] backlight status never sets the summary fault.
// [R25] reserved status bits read zero, writes to them ignored.
// [R26] analog fault levels pass a two-stage synchroniser first.
`timescale 1ns/1ps
module lsr_regs
    import lsr_pkg::*;
#(
    // arbitrary neutral maker code, chosen only to fill the field
    parameter logic [3:0] MAKER_CODE = 4'h5,
    parameter logic [2:0] SILICON_REV = FIRST_REVISION
) (
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    input  wire logic        clk_en,
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata,
    output logic             reg_rvalid,
    input  wire logic        input_overcurrent_raw,
    input  wire logic        thermal_shutdown_raw,
    input  wire logic [5:0]  channel_fault_raw,
    input  wire logic        backlight_on_command,
    input  wire logic        backlight_lit,
    output logic      [7:0]  dc_level_code,
    output logic      [1:0]  short_threshold_select,
    output logic             switch_freq_select,
    output logic      [5:0]  channel_enable_bits
);

    // ones count of the faulted-out channel vector
    function automatic logic [2:0] count_ones(input logic [5:0] v);
        logic [2:0] n;
        n = 3'h0;
        for (int i = 0; i < NUM_CHANNELS; i++) begin
            n = n + {2'b00, v[i]};
        end
        return n;
    endfunction

    // stored registers
    logic [7:0] dc_level;
    logic [7:0] config_reg;
    logic [7:0] channel_mask;
    logic [5:0] channel_faulted;
    logic       fault_sticky;
    logic       backlight_cmd_prev;

    // synchronised monitor levels
    logic [7:0] monitor_raw;
    logic [7:0] monitor_sync;
    logic       overcurrent_flag;
    logic       thermal_flag;
    logic [5:0] channel_fault_flag;

    // raw analog fault levels are not related to sys_clk
    assign monitor_raw = {input_overcurrent_raw, thermal_shutdown_raw, channel_fault_raw};

    lsr_sync #(
        .WIDTH    (8)
    ) u_monitor_sync (
        .sys_clk  (sys_clk),
        .resetn   (resetn),
        .clk_en   (clk_en),
        .async_in (monitor_raw),
        .sync_out (monitor_sync)
    ); // [R26]

    assign overcurrent_flag   = monitor_sync[7];
    assign thermal_flag       = monitor_sync[6];
    assign channel_fault_flag = monitor_sync[5:0];

    // address decode
    logic hit_status;
    logic hit_identity;
    logic hit_dc;
    logic hit_config;
    logic hit_mask;
    logic wr_status;
    logic wr_dc;
    logic wr_config;
    logic wr_mask;

    assign hit_status   = (reg_addr == OFS_FAULT_STATUS);
    assign hit_identity = (reg_addr == OFS_IDENTITY);
    assign hit_dc       = (reg_addr == OFS_DC_LEVEL);
    assign hit_config   = (reg_addr == OFS_CONFIG);
    assign hit_mask     = (reg_addr == OFS_CHANNEL_MASK);
    assign wr_status    = reg_wr && hit_status;
    assign wr_dc        = reg_wr && hit_dc;
    assign wr_config    = reg_wr && hit_config;
    assign wr_mask      = reg_wr && hit_mask;
    // no write strobe exists for the identity offset at all [R3]

    // shutdown flags from the count of faulted-out channels
    logic [2:0] faulted_count;
    logic       one_channel_shutdown;
    logic       two_channel_shutdown;

    assign faulted_count        = count_ones(channel_faulted);
    assign one_channel_shutdown = (faulted_count >= 3'h1); // [R23]
    assign two_channel_shutdown = (faulted_count >= 3'h2); // [R23]

    // live fault conditions; backlight status is left out on purpose [R24]
    logic fault_condition;
    assign fault_condition = overcurrent_flag | thermal_flag
                           | one_channel_shutdown | two_channel_shutdown; // [R9]

    // sticky summary clear: command toggle or a zero written to bit 0
    logic backlight_toggled;
    logic fault_clear;
    logic next_fault_sticky;

    assign backlight_toggled = backlight_on_command ^ backlight_cmd_prev;
    assign fault_clear       = backlight_toggled || (wr_status && !reg_wdata[STS_FAULT_BIT]);
    // set wins over clear, so a persisting fault reappears at once
    assign next_fault_sticky = fault_condition || (fault_sticky && !fault_clear); // [R22]

    // channel fault-out latch; a disabled channel drops its fault
    logic [5:0] mask_bits;
    logic [5:0] next_channel_mask;
    logic [5:0] next_channel_faulted;

    assign mask_bits         = channel_mask[NUM_CHANNELS-1:0]; // [R17]
    assign next_channel_mask = wr_mask ? reg_wdata[NUM_CHANNELS-1:0] : mask_bits;
    // only an enabled channel can fault out; re-enable starts clean [R20]
    assign next_channel_faulted = (channel_faulted | (channel_fault_flag & mask_bits))
                                & next_channel_mask; // [R20]

    // enabled and not faulted out: driven and read back as on
    logic [5:0] live_channels;
    assign live_channels = mask_bits & ~channel_faulted; // [R19]

    // read views
    logic [7:0] status_view;
    logic [7:0] identity_view;
    logic [7:0] mask_view;
    logic [7:0] read_mux;

    always_comb begin
        status_view                    = 8'h00; // reserved bits stay zero [R25]
        status_view[STS_FAULT_BIT]     = fault_sticky; // [R9]
        status_view[STS_THERMAL_BIT]   = thermal_flag; // [R8]
        status_view[STS_OVERCURR_BIT]  = overcurrent_flag; // [R8]
        status_view[STS_BACKLIGHT_BIT] = backlight_lit; // [R7]
        status_view[STS_ONE_SHUT_BIT]  = one_channel_shutdown; // [R6]
        status_view[STS_TWO_SHUT_BIT]  = two_channel_shutdown; // [R6]
    end

    // identity fields; the maker code is the caller's, 15 meaning none
    // implemented, and codes 10 to 14 are reserved so must not be chosen
    logic       panel_driver_marker;
    logic [3:0] maker_code_field;
    logic [2:0] revision_field;

    assign panel_driver_marker = 1'b1; // [R1]
    assign maker_code_field    = MAKER_CODE; // [R2] [R4]
    assign revision_field      = SILICON_REV; // [R5]
    assign identity_view       = {panel_driver_marker, maker_code_field, revision_field}; // [R2]

    // disabled or faulted channels read zero; reserved bits read as stored
    assign mask_view = {channel_mask[7:6], live_channels}; // [R19]

    assign read_mux = hit_status   ? status_view   :
                      hit_identity ? identity_view :
                      hit_dc       ? dc_level      : // [R12]
                      hit_config   ? config_reg    :
                      hit_mask     ? mask_view     :
                                     8'h00;

    // dc level: only this register changes, pwm lives elsewhere
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            dc_level <= RST_DC_LEVEL; // [R13]
        end else if (clk_en && wr_dc) begin
            dc_level <= reg_wdata; // [R10] [R11]
        end
    end

    // boost frequency and short threshold configuration
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            config_reg <= RST_CONFIG; // [R16]
        end else if (clk_en && wr_config) begin
            config_reg <= reg_wdata;
        end
    end

    // channel mask, written whole
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            channel_mask <= RST_CHANNEL_MASK; // [R21]
        end else if (clk_en && wr_mask) begin
            channel_mask <= reg_wdata; // [R18]
        end
    end

    // fault-out latch per channel
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            channel_faulted <= 6'h00;
        end else if (clk_en) begin
            channel_faulted <= next_channel_faulted; // [R20]
        end
    end

    // sticky summary fault bit
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            fault_sticky <= RST_FAULT_STATUS[STS_FAULT_BIT];
        end else if (clk_en) begin
            fault_sticky <= next_fault_sticky; // [R22]
        end
    end

    // last backlight command, kept to see the toggle that clears the summary
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            backlight_cmd_prev <= 1'b0;
        end else if (clk_en) begin
            backlight_cmd_prev <= backlight_on_command;
        end
    end

    // read answer strobe, registered by the taking edge itself
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            reg_rvalid <= 1'b0;
        end else if (clk_en) begin
            reg_rvalid <= reg_rd;
        end
    end

    // read data holds until the next taken read
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= RST_READ_DATA;
        end else if (clk_en && reg_rd) begin
            reg_rdata <= read_mux;
        end
    end

    // dc level copy for the current sinks, registered so it never glitches
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            dc_level_code <= RST_DC_LEVEL;
        end else if (clk_en) begin
            dc_level_code <= dc_level; // [R10]
        end
    end

    // short threshold code, meaning left to the channel comparators
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            short_threshold_select <= RST_CONFIG[CFG_SHORT_LSB +: 2];
        end else if (clk_en) begin
            short_threshold_select <= config_reg[CFG_SHORT_LSB +: 2]; // [R14]
        end
    end

    // boost switching frequency select
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            switch_freq_select <= RST_CONFIG[CFG_FREQ_BIT];
        end else if (clk_en) begin
            switch_freq_select <= config_reg[CFG_FREQ_BIT]; // [R15]
        end
    end

    // channel drive; a faulted channel stays off until disabled and re-enabled
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            channel_enable_bits <= RST_CHANNEL_MASK[NUM_CHANNELS-1:0];
        end else if (clk_en) begin
            channel_enable_bits <= live_channels; // [R18] [R20]
        end
    end

endmodule

// >>> verification/lsr_monitor.sv
// model of the analog monitors that feed the fault levels
// assumes the bench raises shorts and faults as slow levels
`timescale 1ns/1ps
module lsr_monitor (
    input  wire logic [5:0] channel_enable_bits,
    input  wire logic [5:0] string_short,
    input  wire logic       overcurrent_req,
    input  wire logic       overheat_req,
    output logic      [5:0] channel_fault_raw,
    output logic            input_overcurrent_raw,
    output logic            thermal_shutdown_raw
);
    // a shorted string only trips while its sink is driven
    assign channel_fault_raw     = string_short & channel_enable_bits;
    assign input_overcurrent_raw = overcurrent_req;
    assign thermal_shutdown_raw  = overheat_req;
endmodule

// >>> verification/lsr_regs_assertions.sv
// port checker for the led driver register bank
// assumes one clock domain; bound onto every lsr_regs
`timescale 1ns/1ps
module lsr_regs_assertions
    import lsr_pkg::*;
(
    input wire logic       sys_clk,
    input wire logic       resetn,
    input wire logic       clk_en,
    input wire logic [7:0] reg_addr,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic       reg_rvalid,
    input wire logic       input_overcurrent_raw,
    input wire logic       thermal_shutdown_raw,
    input wire logic [5:0] channel_fault_raw,
    input wire logic       backlight_on_command,
    input wire logic       backlight_lit,
    input wire logic [7:0] dc_level_code,
    input wire logic [1:0] short_threshold_select,
    input wire logic       switch_freq_select,
    input wire logic [5:0] channel_enable_bits
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    // taken strobes; rd with wr excluded as the answer is then stale
    wire logic rd_on  = clk_en && reg_rd && !reg_wr;
    wire logic wr_on  = clk_en && reg_wr;
    wire logic rd_sts = rd_on && reg_addr == OFS_FAULT_STATUS;
    wire logic quiet  = clk_en && !reg_wr;

    AST_RVALID: assert property (rd_on |=> reg_rvalid)
        else $error("read not answered");
    AST_ID_MARK: assert property (rd_on && reg_addr == OFS_IDENTITY |=> reg_rdata[ID_MARKER_BIT])
        else $error("identity marker low");
    AST_STS_RSVD: assert property (rd_sts |=> reg_rdata[7:6] == 2'h0)
        else $error("reserved status bits set");
    AST_STS_BL: assert property (rd_sts |=> reg_rdata[STS_BACKLIGHT_BIT] == $past(backlight_lit))
        else $error("backlight status wrong");
    // four cycles: two synchroniser stages, the sticky bit, then the read
    AST_OVERCURR: assert property ((clk_en && input_overcurrent_raw)[*4] ##0 rd_sts |=>
        reg_rdata[STS_OVERCURR_BIT] && reg_rdata[STS_FAULT_BIT])
        else $error("overcurrent not reported");
    AST_THERMAL: assert property ((clk_en && thermal_shutdown_raw)[*3] ##0 rd_sts |=>
        reg_rdata[STS_THERMAL_BIT])
        else $error("thermal fault not reported");
    AST_DC_WR: assert property (wr_on && reg_addr == OFS_DC_LEVEL ##1 quiet |=>
        dc_level_code == $past(reg_wdata, 2))
        else $error("dc level output wrong");
    AST_CFG_WR: assert property (wr_on && reg_addr == OFS_CONFIG ##1 quiet |=>
        {5'h0, switch_freq_select, short_threshold_select} == ($past(reg_wdata, 2) & 8'h07))
        else $error("config outputs wrong");
    AST_MASK_OFF: assert property (wr_on && reg_addr == OFS_CHANNEL_MASK ##1 quiet |=>
        ({2'h0, channel_enable_bits} & ~$past(reg_wdata, 2)) == 8'h00)
        else $error("disabled channel still on");

    cover property (rd_sts ##1 reg_rdata[STS_ONE_SHUT_BIT]);
    cover property (rd_sts ##1 reg_rdata[STS_TWO_SHUT_BIT]);
    cover property (wr_on && reg_addr == OFS_CHANNEL_MASK);
endmodule

bind lsr_regs lsr_regs_assertions u_chk (.sys_clk, .resetn, .clk_en, .reg_addr, .reg_wr, .reg_rd,
    .reg_wdata, .reg_rdata, .reg_rvalid, .input_overcurrent_raw, .thermal_shutdown_raw,
    .channel_fault_raw, .backlight_on_command, .backlight_lit, .dc_level_code,
    .short_threshold_select, .switch_freq_select, .channel_enable_bits);

// >>> verification/tb.sv
// self-checking bench for the led driver register bank
// assumes the monitor model and the bound checker compile first
`timescale 1ns/1ps
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin bad_count++; $display("ERROR %s expected %h seen %h", n, e, s); end end
module tb
    import lsr_pkg::*;
;
    localparam logic [3:0] TB_MAKER = 4'h3; // arbitrary maker code
    localparam logic [7:0] ID_EXP   = {1'b1, TB_MAKER, FIRST_REVISION};
    logic       sys_clk = 1'b0, resetn = 1'b0, clk_en = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, dc_level_code;
    logic       reg_rvalid, input_overcurrent_raw, thermal_shutdown_raw, switch_freq_select;
    logic       backlight_on_command = 1'b0, backlight_lit = 1'b0, overcurrent_req = 1'b0, overheat_req = 1'b0;
    logic [5:0] channel_fault_raw, channel_enable_bits, string_short = 6'h00;
    logic [1:0] short_threshold_select;
    logic [7:0] dc_codes [4] = '{8'h00, 8'h01, 8'h80, 8'hfe};
    int         bad_count = 0;
    int         comparisons = 0;

    always #10 sys_clk = ~sys_clk;

    lsr_regs #(.MAKER_CODE(TB_MAKER)) uut (.sys_clk, .resetn, .clk_en, .reg_addr, .reg_wr, .reg_rd,
        .reg_wdata, .reg_rdata, .reg_rvalid, .input_overcurrent_raw, .thermal_shutdown_raw,
        .channel_fault_raw, .backlight_on_command, .backlight_lit, .dc_level_code,
        .short_threshold_select, .switch_freq_select, .channel_enable_bits);
    lsr_monitor u_mon (.channel_enable_bits, .string_short, .overcurrent_req, .overheat_req,
        .channel_fault_raw, .input_overcurrent_raw, .thermal_shutdown_raw);

    // one-cycle write strobe, then an idle edge so calls can follow at once
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        @(posedge sys_clk);
    endtask

    // answer is registered by the taking edge itself and checked 1 ns after it
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        `CHK("rvalid", 1'b1, reg_rvalid)
        `CHK($sformatf("reg %h", a), e, reg_rdata)
        @(posedge sys_clk);
    endtask

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // hang guard
    initial begin
        repeat (5000) @(posedge sys_clk);
        bad_count++;
        report_and_stop;
    end

    initial begin
        repeat (12) @(posedge sys_clk);
        resetn <= 1'b1;
        @(posedge sys_clk);
        `CHK("dc out", 8'hff, dc_level_code)
        `CHK("cfg out", 3'h7, {switch_freq_select, short_threshold_select})
        `CHK("chan out", 6'h3f, channel_enable_bits)
        rdc(OFS_DC_LEVEL, 8'hff);
        rdc(OFS_CONFIG, 8'hff);
        rdc(OFS_CHANNEL_MASK, 8'hff);
        rdc(OFS_FAULT_STATUS, 8'h00);
        rdc(OFS_IDENTITY, ID_EXP);
        wr(OFS_IDENTITY, 8'h00);
        rdc(OFS_IDENTITY, ID_EXP);
        wr(8'h0a, 8'h55);
        rdc(8'h0a, 8'h00);
        // boundary dc codes must leave config untouched
        foreach (dc_codes[i]) begin
            wr(OFS_DC_LEVEL, dc_codes[i]);
            rdc(OFS_DC_LEVEL, dc_codes[i]);
            `CHK("dc out", dc_codes[i], dc_level_code)
            `CHK("cfg out", 3'h7, {switch_freq_select, short_threshold_select})
        end
        // frozen clock enable drops the write
        clk_en <= 1'b0;
        wr(OFS_DC_LEVEL, 8'h11);
        clk_en <= 1'b1;
        rdc(OFS_DC_LEVEL, 8'hfe);
        for (int i = 0; i < 8; i++) begin
            wr(OFS_CONFIG, 8'(i));
            rdc(OFS_CONFIG, 8'(i));
            `CHK("thr out", 2'(i), short_threshold_select)
            `CHK("freq out", 1'(i >> 2), switch_freq_select)
        end
        wr(OFS_CHANNEL_MASK, 8'h15);
        rdc(OFS_CHANNEL_MASK, 8'h15);
        `CHK("chan out", 6'h15, channel_enable_bits)
        wr(OFS_CHANNEL_MASK, 8'h3f);
        // one string faults out and stays out after its short clears
        backlight_lit <= 1'b1;
        string_short  <= 6'h04;
        repeat (4) @(posedge sys_clk);
        string_short <= 6'h00;
        rdc(OFS_CHANNEL_MASK, 8'h3b);
        rdc(OFS_FAULT_STATUS, 8'h19);
        wr(OFS_CHANNEL_MASK, 8'h3b);
        wr(OFS_CHANNEL_MASK, 8'h3f);
        rdc(OFS_CHANNEL_MASK, 8'h3f);
        rdc(OFS_FAULT_STATUS, 8'h09);
        // a one written to the summary bit must not clear it
        wr(OFS_FAULT_STATUS, 8'h01);
        rdc(OFS_FAULT_STATUS, 8'h09);
        backlight_on_command <= 1'b1;
        @(posedge sys_clk);
        rdc(OFS_FAULT_STATUS, 8'h08);
        string_short <= 6'h03;
        repeat (4) @(posedge sys_clk);
        string_short <= 6'h00;
        rdc(OFS_FAULT_STATUS, 8'h39);
        wr(OFS_CHANNEL_MASK, 8'h00);
        wr(OFS_CHANNEL_MASK, 8'h3f);
        wr(OFS_FAULT_STATUS, 8'hfe);
        rdc(OFS_FAULT_STATUS, 8'h08);
        overcurrent_req <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rdc(OFS_FAULT_STATUS, 8'h0d);
        overcurrent_req <= 1'b0;
        overheat_req    <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rdc(OFS_FAULT_STATUS, 8'h0b);
        overheat_req  <= 1'b0;
        backlight_lit <= 1'b0;
        repeat (3) @(posedge sys_clk);
        wr(OFS_FAULT_STATUS, 8'h00);
        rdc(OFS_FAULT_STATUS, 8'h00);
        report_and_stop;
    end
endmodule
